/* File: logic/ctst_timer.sv */
// can time stamp timer with avalon-mm slave and overflow interrupt
module ctst_timer #(
   parameter int COUNT_W = 16,
   parameter int PRE_W = 16
) (
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // avalon-mm slave
   input wire logic [4:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // interrupt
   output logic irq_o
);
   // all state but the two reset release flops lives in one record: the comb block builds the next copy
   // and a single register stores it, so none of it escapes the clock enable
   // or the reset; the cost is that every field is reset, wanted or not
   typedef struct packed {
      logic [COUNT_W-1:0] count;
      logic [PRE_W-1:0] setting;
      logic [PRE_W-1:0] pre_cnt;
      logic capture;
      logic [31:0] status;
      logic [31:0] enable;
      logic [31:0] rdata;
      logic busy;
      logic irq;
   } ctst_state_t;

   // busy is up out of reset: waitrequest stays high until the block runs
   localparam ctst_state_t STATE_RESET = '{busy: 1'b1, default: '0};

   // select lines, one per register
   localparam int SEL_TIMER = 0;
   localparam int SEL_CONTROL = 1;
   localparam int SEL_STATUS = 2;
   localparam int SEL_CLEAR = 3;
   localparam int SEL_ENABLE = 4;

   ctst_state_t s_q;
   ctst_state_t s_d;
   logic rst_meta_q;
   logic rst_sync_q;

   // ==========================================================
   // reset release
   // the reset copy is left out of the clock enable so that a frozen
   // block still leaves and enters reset cleanly
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // byte-lane merge, used for every writable register
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ==========================================================
   // register select, shared by the read and the write path
   function automatic logic [4:0] decode(input logic [4:0] addr);
      logic [4:0] sel;
      sel = 5'h00;
      // the upper address bit is decoded for every register, so the low four do not alias at 0x10-0x1C
      case (addr)
         {1'b0, ctst_pkg::TIMER_OFFSET}:
         begin
            sel[SEL_TIMER] = 1'b1;
         end
         {1'b0, ctst_pkg::CONTROL_OFFSET}:
         begin
            sel[SEL_CONTROL] = 1'b1;
         end
         {1'b0, ctst_pkg::IRQ_STATUS_OFFSET}:
         begin
            sel[SEL_STATUS] = 1'b1;
         end
         {1'b0, ctst_pkg::IRQ_CLEAR_OFFSET}:
         begin
            sel[SEL_CLEAR] = 1'b1;
         end
         ctst_pkg::IRQ_ENABLE_OFFSET:
         begin
            sel[SEL_ENABLE] = 1'b1;
         end
         default:
         begin
            sel = 5'h00;
         end
      endcase
      return sel;
   endfunction : decode

   // timer word as software sees it
   function automatic logic [31:0] pack_timer(input logic [COUNT_W-1:0] cnt,
                                              input logic [PRE_W-1:0] pre);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ctst_pkg::COUNT_LSB +: COUNT_W] = cnt;
      w[ctst_pkg::PRESCALE_LSB +: PRE_W] = pre;
      return w;
   endfunction : pack_timer

   // the period is the setting itself, zero taken as one, so that zero
   // steps every clock and all ones every 65535 clocks; a setting of one
   // therefore behaves like zero
   function automatic logic period_done(input logic [PRE_W-1:0] cnt,
                                        input logic [PRE_W-1:0] pre);
      logic [PRE_W:0] next_v;
      next_v = {1'b0, cnt} + {{PRE_W{1'b0}}, 1'b1};
      return next_v >= {1'b0, pre};
   endfunction : period_done

   // level interrupt, taken from the next state so irq_o is a flop
   function automatic logic irq_level(input logic [31:0] status,
                                      input logic [31:0] enable);
      return |(status & enable);
   endfunction : irq_level

   // ==========================================================
   // next state
   always_comb
   begin
      logic [31:0] timer_word;
      logic [31:0] tw;
      logic [31:0] ctl;
      logic [4:0] sel;
      logic tick;
      logic wrap;
      logic req;
      timer_word = pack_timer(s_q.count, s_q.setting);
      tw = 32'h0000_0000;
      ctl = 32'h0000_0000;
      sel = decode(address_i);
      tick = 1'b0;
      wrap = 1'b0;
      req = 1'b0;
      s_d = s_q;
      ctl[ctst_pkg::CAPTURE_BIT] = s_q.capture;

      // prescaler and count
      // with capture off neither counter moves, so a paused stamp resumes
      // exactly where it stopped
      if (s_q.capture)
      begin
         if (period_done(s_q.pre_cnt, s_q.setting))
         begin
            s_d.pre_cnt = '0;
            tick = 1'b1;
         end
         else
         begin
            s_d.pre_cnt = PRE_W'(s_q.pre_cnt + 1'b1);
         end
      end
      if (tick)
      begin
         s_d.count = COUNT_W'(s_q.count + 1'b1);
         wrap = &s_q.count;
      end

      // bus access
      // one wait cycle per access: busy drops in the cycle after the take,
      // and the next request is only looked at once busy is back up
      s_d.busy = 1'b1;
      req = (read_i || write_i) && s_q.busy;
      if (req && write_i)
      begin
         s_d.busy = 1'b0;
         if (sel[SEL_TIMER])
         begin
            tw = merge(timer_word, writedata_i, byteenable_i);
            s_d.count = tw[ctst_pkg::COUNT_LSB +: COUNT_W];
            s_d.setting = tw[ctst_pkg::PRESCALE_LSB +: PRE_W];
            s_d.pre_cnt = '0;
            // the written count replaces one that would have wrapped
            wrap = 1'b0;
         end
         if (sel[SEL_CONTROL])
         begin
            tw = merge(ctl, writedata_i, byteenable_i);
            s_d.capture = tw[ctst_pkg::CAPTURE_BIT];
         end
         if (sel[SEL_CLEAR])
         begin
            tw = merge(32'h0000_0000, writedata_i, byteenable_i);
            s_d.status = s_q.status & ~tw;
         end
         if (sel[SEL_ENABLE])
         begin
            // only the overflow source exists, other enables read zero
            tw = merge(s_q.enable, writedata_i, byteenable_i);
            s_d.enable = 32'h0000_0000;
            s_d.enable[ctst_pkg::OVERFLOW_BIT] =
               tw[ctst_pkg::OVERFLOW_BIT];
         end
      end
      if (req && read_i)
      begin
         s_d.busy = 1'b0;
         // the clear register and the holes read as zero
         s_d.rdata = ctst_pkg::READ_UNMAPPED;
         if (sel[SEL_TIMER])
         begin
            s_d.rdata = timer_word;
         end
         if (sel[SEL_CONTROL])
         begin
            s_d.rdata = ctl;
         end
         if (sel[SEL_STATUS])
         begin
            s_d.rdata = s_q.status;
         end
         if (sel[SEL_ENABLE])
         begin
            s_d.rdata = s_q.enable;
         end
      end

      // interrupt
      // set after clear so a same-cycle overflow is kept
      if (wrap)
      begin
         s_d.status[ctst_pkg::OVERFLOW_BIT] = 1'b1;
      end
      s_d.irq = irq_level(s_d.status, s_d.enable);
   end

   // ==========================================================
   // state register
   // clk_en_i low holds every field, bus answer included, so a request
   // that arrives while frozen is taken once the enable returns
   always_ff @(posedge clock_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         s_q <= STATE_RESET;
      end
      else if (clk_en_i)
      begin
         s_q <= s_d;
      end
   end

   assign readdata_o = s_q.rdata;
   assign waitrequest_o = s_q.busy;
   assign irq_o = s_q.irq;
endmodule : ctst_timer

/* File: logic/ctst_pkg.sv */
// constants for the can time stamp timer block
package ctst_pkg;
   // ==========================================================
   // register map, byte addresses
   localparam logic [3:0] TIMER_OFFSET = 4'h0;
   localparam logic [3:0] CONTROL_OFFSET = 4'h4;
   localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
   localparam logic [3:0] IRQ_CLEAR_OFFSET = 4'hC;
   // second nibble, offset 0x10
   localparam logic [4:0] IRQ_ENABLE_OFFSET = 5'h10;
   // ==========================================================
   // field positions
   localparam int COUNT_LSB = 16;
   localparam int PRESCALE_LSB = 0;
   localparam int CAPTURE_BIT = 20;
   localparam int OVERFLOW_BIT = 2;
   // ==========================================================
   // reset value and the read value of unmapped addresses
   localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : ctst_pkg

/* File: verification/ctst_checker.sv */
// port assertions for the time stamp timer
module ctst_checker (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic [4:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire logic irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   wait_one_a: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low twice");
   ans_bound_a: assert property ((read_i || write_i) && clk_en_i
      |-> ##[0:3] !waitrequest_o) else $error("no bus answer");
   ans_cause_a: assert property (!waitrequest_o |-> read_i || write_i)
      else $error("answer without request");
   unmap_zero_a: assert property (!waitrequest_o && read_i
      && address_i > 5'h10 |-> readdata_o == 32'h0) else $error("unmapped");
   clear_zero_a: assert property (!waitrequest_o && read_i
      && address_i == 5'h0C |-> readdata_o == 32'h0) else $error("clr read");
   reset_irq_a: assert property ($rose(rst_b_i) |-> !irq_o)
      else $error("irq after reset");
   irq_fall_a: assert property ($fell(irq_o) |-> $past(write_i)
      || $past(write_i, 2) || $past(write_i, 3)) else $error("irq fell");
endmodule : ctst_checker
bind ctst_timer ctst_checker i_chk (.clock_i, .rst_b_i, .clk_en_i,
   .address_i, .read_i, .write_i, .readdata_o, .waitrequest_o, .irq_o);

/* File: verification/ctst_timer_tb_top.sv */
// self-checking bench for the time stamp timer
module ctst_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic clk_en_i = 1'h1;
   logic [4:0] address_i = 5'h0;
   logic read_i = 1'h0;
   logic write_i = 1'h0;
   logic [31:0] writedata_i = 32'h0;
   logic [3:0] byteenable_i = 4'hF;
   logic [31:0] readdata_o, q, e, s = 32'hC504;
   logic waitrequest_o, irq_o;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 clock_i = ~clock_i;
   ctst_timer i_dut (.clock_i, .rst_b_i, .clk_en_i, .address_i, .read_i,
      .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
      .irq_o);
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : rnd
   // bit 16 flags a wrap; k+3 enabled clocks lie between the two writes;
   // the period is the setting, a zero setting taken as one clock
   function automatic logic [16:0] after(logic [15:0] c, p, int k);
      return {1'h0, c} + 17'((k + 3) / (p == 16'h0 ? 1 : int'(p)));
   endfunction : after
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         $display("mismatch %s expected %h seen %h", n, x, g);
         err_total++;
      end
   endtask : chk
   task automatic summarize();
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
      @(posedge clock_i);
      read_i <= !w;
      write_i <= w;
      address_i <= a;
      writedata_i <= d;
      do @(posedge clock_i); while (waitrequest_o !== 1'h0);
      q = readdata_o;
      read_i <= 1'h0;
      write_i <= 1'h0;
   endtask : bus
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc > 90000)
      begin
         err_total++;
         summarize();
      end
   end
   initial
   begin
      logic [15:0] c, p;
      logic [16:0] r;
      int k;
      repeat (10) @(posedge clock_i);
      rst_b_i <= 1'h1;
      repeat (3) @(posedge clock_i);
      bus(1'h0, 5'h00, 32'h0);
      chk("timer", 32'h0, q);
      bus(1'h0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 6; i++)
      begin
         e = rnd();
         // first pass: widest prescaler from zero, the rest wrap often
         c = i == 0 ? 16'h0 : 16'hFFF0 + 16'(e[3:0]);
         p = i == 0 ? 16'hFFFF : 16'(e[5:4]);
         k = i == 0 ? 65532 : int'(e[11:8]);
         r = after(c, p, k);
         bus(1'h1, 5'h10, {29'h0, i[0], 2'h0});
         bus(1'h1, 5'h00, {c, p});
         bus(1'h1, 5'h04, 32'h0010_0000);
         repeat (k) @(posedge clock_i);
         // frozen clocks must not advance either counter
         clk_en_i <= 1'h0;
         repeat (5) @(posedge clock_i);
         clk_en_i <= 1'h1;
         bus(1'h1, 5'h04, 32'h0);
         bus(1'h0, 5'h00, 32'h0);
         chk("count", {r[15:0], p}, q);
         bus(1'h0, 5'h08, 32'h0);
         chk("status", {29'h0, r[16], 2'h0}, q);
         chk("irq", {31'h0, r[16] & i[0]}, {31'h0, irq_o});
         bus(1'h0, 5'h00, 32'h0);
         chk("hold", {r[15:0], p}, q);
         bus(1'h1, 5'h0C, 32'h4);
         bus(1'h0, 5'h0C, 32'h0);
         chk("clear", 32'h0, q);
         bus(1'h0, 5'h08, 32'h0);
         chk("cleared", 32'h0, q);
      end
      summarize();
   end
endmodule : ctst_timer_tb_top
